// *** inc/dsw_pkg.sv ***
// shared constants and types for the two-stage watchdog
package dsw_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned STAGE1_MS = 20;
   localparam int unsigned STAGE2_MS = 10;
   localparam int unsigned STAGE1_CYCLES = STAGE1_MS * (CLK_HZ / 1000);
   localparam int unsigned STAGE2_CYCLES = STAGE2_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 22;
   localparam logic [7:0] OUTPUTS_RESET = 8'h00;
   // gray-coded along first stage, second stage, hold
   typedef enum logic [1:0] {
      DSW_STAGE1 = 2'b00,
      DSW_STAGE2 = 2'b01,
      DSW_HOLD = 2'b11,
      DSW_IDLE = 2'b10
   } dsw_state_type;
endpackage

// *** rtl/dsw_timer.sv ***
// loadable down counter that pulses once when it runs out
`timescale 1ns/10ps
module dsw_timer #(
   parameter int W = 22
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic load_in,
   input wire logic [W-1:0] load_value_in,
   input wire logic run_in,
   output logic expired_out
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic expired_r;
   logic expired_nxt;

   always_comb begin
      count_nxt = count_r;
      expired_nxt = 1'b0;
      if (load_in) begin
         count_nxt = load_value_in;
      end else if (run_in && count_r != '0) begin
         count_nxt = count_r - 1'b1;
         expired_nxt = (count_r == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_r <= '0;
         expired_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign expired_out = expired_r;
endmodule

// *** rtl/dsw_watchdog.sv ***
// two-stage watchdog with interrupt, output clear and grant hold
//
// How it works
// - reset starts 20 ms first stage
// - first expiry pulses power-loss or load interrupt
// - first expiry clears outputs when enabled
// - then 10 ms stage; expiry asserts grant hold
// - grant hold stays until system reset
`timescale 1ns/10ps
module dsw_watchdog #(
   parameter int unsigned STAGE1_LEN = dsw_pkg::STAGE1_CYCLES,
   parameter int unsigned STAGE2_LEN = dsw_pkg::STAGE2_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic retrigger_in,
   input wire logic sel_load_irq_in,
   input wire logic clear_outputs_en_in,
   input wire logic grant_hold_en_in,
   input wire logic [7:0] outputs_wr_data_in,
   input wire logic outputs_wr_in,
   output logic power_loss_interrupt_out,
   output logic load_interrupt_out,
   output logic priority_grant_out,
   output logic [7:0] power_outputs_out,
   output dsw_pkg::dsw_state_type state_out
);
   import dsw_pkg::*;

   dsw_state_type state_r, state_nxt;
   logic [7:0] outs_r, outs_nxt;
   logic pwr_irq_r, pwr_irq_nxt, load_irq_r, load_irq_nxt;
   logic grant_r, grant_nxt;
   logic first_r, first_nxt;
   logic load_t, expired;
   logic [CNT_W-1:0] load_val;

   dsw_timer #(.W(CNT_W)) u_timer (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .load_in(load_t),
      .load_value_in(load_val),
      .run_in(state_r == DSW_STAGE1 || state_r == DSW_STAGE2),
      .expired_out(expired)
   );

   always_comb begin
      state_nxt = state_r;
      outs_nxt = outs_r;
      pwr_irq_nxt = 1'b0;
      load_irq_nxt = 1'b0;
      grant_nxt = grant_r;
      first_nxt = 1'b0;
      load_t = first_r;
      load_val = CNT_W'(STAGE1_LEN);
      if (outputs_wr_in) begin
         outs_nxt = outputs_wr_data_in;
      end
      unique case (state_r)
         DSW_STAGE1: begin
            if (retrigger_in) begin
               load_t = 1'b1;
            end else if (expired) begin
               state_nxt = DSW_STAGE2;
               load_t = 1'b1;
               load_val = CNT_W'(STAGE2_LEN);
               pwr_irq_nxt = !sel_load_irq_in;
               load_irq_nxt = sel_load_irq_in;
               if (clear_outputs_en_in) begin
                  outs_nxt = OUTPUTS_RESET;
               end
            end
         end
         DSW_STAGE2: begin
            if (retrigger_in) begin
               state_nxt = DSW_STAGE1;
               load_t = 1'b1;
            end else if (expired) begin
               if (grant_hold_en_in) begin
                  state_nxt = DSW_HOLD;
                  grant_nxt = 1'b1;
               end else begin
                  state_nxt = DSW_IDLE;
               end
            end
         end
         DSW_HOLD: begin
            grant_nxt = 1'b1;
         end
         DSW_IDLE: begin
            if (retrigger_in) begin
               state_nxt = DSW_STAGE1;
               load_t = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= DSW_STAGE1;
         first_r <= 1'b1;
         outs_r <= OUTPUTS_RESET;
         pwr_irq_r <= 1'b0;
         load_irq_r <= 1'b0;
         grant_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         first_r <= first_nxt;
         outs_r <= outs_nxt;
         pwr_irq_r <= pwr_irq_nxt;
         load_irq_r <= load_irq_nxt;
         grant_r <= grant_nxt;
      end
   end

   assign power_loss_interrupt_out = pwr_irq_r;
   assign load_interrupt_out = load_irq_r;
   assign priority_grant_out = grant_r;
   assign power_outputs_out = outs_r;
   assign state_out = state_r;

   // cycles since the running stage was loaded; zero from the second cycle outside the two timed stages
   // checker only: lets the stage lengths be judged independently of the timer
   logic [CNT_W-1:0] age_r;
   logic [CNT_W-1:0] age_nxt;

   always_comb begin
      age_nxt = age_r;
      if (load_t || !(state_r == DSW_STAGE1 || state_r == DSW_STAGE2)) begin
         age_nxt = '0;
      end else if (age_r != '1) begin
         age_nxt = age_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         age_r <= '0;
      end else begin
         age_r <= age_nxt;
      end
   end

   // first stage: neither shorter nor longer than its load
   stage1_len_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE1 && age_r < CNT_W'(STAGE1_LEN - 1)) |=> state_r != DSW_STAGE2)
      else $error("first stage ended early");

   stage1_late_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE1 && age_r == CNT_W'(STAGE1_LEN) && !retrigger_in)
      |=> state_r == DSW_STAGE2)
      else $error("first stage ran too long");

   // interrupt line choice and pulse shape
   irq_select_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE1 && $past(state_r) == DSW_STAGE1 && state_nxt == DSW_STAGE2)
      |=> (power_loss_interrupt_out == !$past(sel_load_irq_in)
           && load_interrupt_out == $past(sel_load_irq_in)))
      else $error("wrong interrupt line on first expiry");

   irq_only_expiry_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (power_loss_interrupt_out || load_interrupt_out) |-> state_r == DSW_STAGE2
      && $past(state_r) == DSW_STAGE1)
      else $error("interrupt without first expiry");

   irq_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (power_loss_interrupt_out || load_interrupt_out)
      |=> !power_loss_interrupt_out && !load_interrupt_out)
      else $error("interrupt longer than one cycle");

   irq_one_line_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      !(power_loss_interrupt_out && load_interrupt_out))
      else $error("both interrupt lines raised");

   // output latch: writes land, expiry clears only when enabled
   outs_write_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (outputs_wr_in
       && !(state_r == DSW_STAGE1 && state_nxt == DSW_STAGE2 && clear_outputs_en_in))
      |=> power_outputs_out == $past(outputs_wr_data_in))
      else $error("output write lost");

   outs_clear_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE1 && state_nxt == DSW_STAGE2 && clear_outputs_en_in)
      |=> power_outputs_out == OUTPUTS_RESET)
      else $error("outputs not cleared");

   outs_keep_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE1 && state_nxt == DSW_STAGE2 && !clear_outputs_en_in
       && !outputs_wr_in) |=> $stable(power_outputs_out))
      else $error("outputs changed without clear");

   // second stage length and its outcome
   stage2_len_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE2 && age_r < CNT_W'(STAGE2_LEN - 1))
      |=> state_r != DSW_HOLD && state_r != DSW_IDLE)
      else $error("second stage ended early");

   stage2_late_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_r == DSW_STAGE2 && age_r == CNT_W'(STAGE2_LEN) && !retrigger_in)
      |=> state_r == ($past(grant_hold_en_in) ? DSW_HOLD : DSW_IDLE))
      else $error("second stage ran too long");

   grant_cause_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(priority_grant_out) |-> $past(state_r) == DSW_STAGE2 && $past(grant_hold_en_in))
      else $error("grant asserted without second expiry");

   grant_idle_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_r == DSW_IDLE |-> !priority_grant_out)
      else $error("grant raised while hold disabled");

   // once held, only the system reset lets go
   grant_hold_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      priority_grant_out |=> priority_grant_out && state_r == DSW_HOLD)
      else $error("grant hold released");

   retrig_restart_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (retrigger_in && state_r != DSW_HOLD) |=> state_r == DSW_STAGE1 ##1 state_r == DSW_STAGE1)
      else $error("retrigger did not restart first stage");
endmodule

// *** tb/dsw_bus_model.sv ***
// processor side model that retriggers the watchdog by bus writes
`timescale 1ns/10ps
module dsw_bus_model #(
   parameter int PERIOD = 8
) (
   input wire logic clk_sys_in,
   input wire logic alive_in,
   output logic retrigger_out = 1'b0
);
   int n = 0;
   // one-cycle write pulse each period while software is alive
   always @(posedge clk_sys_in) begin
      n <= (n + 1) % PERIOD;
      retrigger_out <= alive_in && n == 0;
   end
endmodule

// *** tb/test_dual_stage_watchdog.sv ***
// self-checking bench for the two-stage watchdog
`timescale 1ns/10ps
module test_dual_stage_watchdog;
   import dsw_pkg::*;
   logic clk_sys_in = 0, reset_n_in = 0, alive = 0, sel = 0, clr = 0, hold = 1, wr = 0;
   logic [7:0] wd = 8'h00;
   logic retrig, pl, li, grant, irq_seen;
   logic [7:0] po;
   dsw_state_type st;
   int num_errors = 0, checks = 0, cyc = 0, n;
   always #4 clk_sys_in = ~clk_sys_in;
   dsw_bus_model bus_u (.clk_sys_in(clk_sys_in), .alive_in(alive), .retrigger_out(retrig));
   dsw_watchdog #(.STAGE1_LEN(20), .STAGE2_LEN(10)) dut_u (.clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in), .retrigger_in(retrig), .sel_load_irq_in(sel),
      .clear_outputs_en_in(clr), .grant_hold_en_in(hold), .outputs_wr_data_in(wd),
      .outputs_wr_in(wr), .power_loss_interrupt_out(pl), .load_interrupt_out(li),
      .priority_grant_out(grant), .power_outputs_out(po), .state_out(st));
   always @(posedge clk_sys_in) begin
      irq_seen <= reset_n_in && (irq_seen === 1'b1 || pl === 1'b1 || li === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         num_errors++;
         finish_test();
      end
   end
   task check(string what, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task do_reset(logic s, logic c, logic h, logic [7:0] d);
      reset_n_in <= 0;
      sel <= s;
      clr <= c;
      hold <= h;
      repeat (16) @(posedge clk_sys_in);
      reset_n_in <= 1;
      wd <= d;
      wr <= 1;
      @(posedge clk_sys_in);
      wr <= 0;
   endtask
   task wait_irq();
      for (n = 0; n < 40 && pl !== 1'b1 && li !== 1'b1; n++) @(posedge clk_sys_in);
   endtask
   task t_alive_hold();
      do_reset(0, 0, 1, 8'h5a);
      alive <= 1;
      repeat (80) @(posedge clk_sys_in);
      check("early irq", irq_seen, 0);
      check("state alive", st, DSW_STAGE1);
      alive <= 0;
      wait_irq();
      check("stage one length", n >= 12, 1);
      check("power loss irq", pl, 1);
      check("load irq", li, 0);
      check("outputs kept", po, 8'h5a);
      for (n = 0; n < 30 && grant !== 1'b1; n++) @(posedge clk_sys_in);
      check("stage two cycles", n, 8'd11);
      check("grant", grant, 1);
      check("state hold", st, DSW_HOLD);
      alive <= 1;
      repeat (30) @(posedge clk_sys_in);
      check("grant held", grant, 1);
      alive <= 0;
      $display("test alive_hold done");
   endtask
   task t_load_idle();
      do_reset(1, 1, 0, 8'hc3);
      check("grant after reset", grant, 0);
      wait_irq();
      check("stage one cycles", n, 8'd22);
      check("load irq", li, 1);
      check("power loss irq", pl, 0);
      check("outputs cleared", po, 8'h00);
      repeat (25) @(posedge clk_sys_in);
      check("grant disabled", grant, 0);
      check("state idle", st, DSW_IDLE);
      alive <= 1;
      repeat (12) @(posedge clk_sys_in);
      check("state restart", st, DSW_STAGE1);
      $display("test load_idle done");
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      t_alive_hold();
      t_load_idle();
      finish_test();
   end
endmodule
